// ---- hdl/mdc_pkg.sv ----
// Shared constants and types for the motor driver I/O configuration block
package mdc_pkg;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int PW = 24;
   localparam int CW = 7;

   localparam logic [AW-1:0] CFG_OFF = 8'h00;
   localparam logic [AW-1:0] OUTSEL_OFF = 8'h04;
   localparam logic [AW-1:0] PRESET_OFF = 8'h08;
   localparam logic [AW-1:0] AREA1_OFF = 8'h0c;
   localparam logic [AW-1:0] AREA2_OFF = 8'h10;
   localparam logic [AW-1:0] ENC_OFF = 8'h14;
   localparam logic [AW-1:0] CUR_OFF = 8'h18;
   localparam logic [AW-1:0] LINK_OFF = 8'h1c;
   localparam logic [AW-1:0] STAT_OFF = 8'h20;

   // Configuration word, bit 0 is start_src
   typedef struct packed {
      logic ot_decel;
      logic sensor_a_nc;
      logic origin_nc;
      logic limit_nc;
      logic ot_en;
      logic release_nc;
      logic data_src;
      logic motion_src;
      logic excite_src;
      logic home_preset_sel;
      logic excite_pol;
      logic stop_nc;
      logic [1:0] stop_action;
      logic stop_en;
      logic start_src;
   } mdc_cfg_s;
   localparam logic [15:0] CFG_RST = 16'h0b97;

   // Commands written over the serial link, bit 0 is start
   typedef struct packed {
      logic [3:0] rout;
      logic [5:0] data_sel;
      logic jog_neg;
      logic jog_pos;
      logic home;
      logic excite;
      logic stop;
      logic start;
   } mdc_link_s;
   localparam logic [15:0] LINK_RST = 16'h0000;

   typedef struct packed {
      logic start;
      logic stop;
      logic excite;
      logic home;
      logic jog_pos;
      logic jog_neg;
      logic [5:0] data_sel;
      logic winding_release;
      logic limit_pos;
      logic limit_neg;
      logic origin_sensor;
      logic sensor_a;
   } mdc_wired_s;

   typedef struct packed {
      logic step_phase_timing;
      logic ready;
      logic warning_flag;
      logic at_origin;
      logic encoder_zero_phase;
      logic misstep;
      logic overheat;
      logic homing;
      logic standstill;
   } mdc_stat_s;

   typedef struct packed {
      logic start;
      logic stop_imm;
      logic stop_decel;
      logic current_off;
      logic excite;
      logic home;
      logic preset;
      logic jog_pos;
      logic jog_neg;
      logic [5:0] data_sel;
      logic ot_imm;
      logic ot_decel;
      logic origin;
      logic sensor_a;
      logic limit_pos;
      logic limit_neg;
   } mdc_cmd_s;

   localparam logic [1:0] STOP_IMM = 2'h0;
   localparam logic [1:0] STOP_DECEL = 2'h1;
   localparam logic [1:0] STOP_IMM_OFF = 2'h2;
   localparam logic [1:0] STOP_DECEL_OFF = 2'h3;

   localparam logic [4:0] OSEL_AREA = 5'h05;
   localparam logic [4:0] OSEL_TIM = 5'h06;
   localparam logic [4:0] OSEL_READY = 5'h07;
   localparam logic [4:0] OSEL_WARN = 5'h08;
   localparam logic [4:0] OSEL_ORIGIN = 5'h09;
   localparam logic [4:0] OSEL_ZERO = 5'h0a;
   localparam logic [4:0] OSEL_ROUT1 = 5'h0b;
   localparam logic [4:0] OSEL_ROUT2 = 5'h0c;
   localparam logic [4:0] OSEL_MISSTEP = 5'h0d;
   localparam logic [4:0] OSEL_HEAT = 5'h0e;
   localparam logic [4:0] OSEL_ROUT3 = 5'h0f;
   localparam logic [4:0] OSEL_ROUT4 = 5'h10;
   localparam logic [31:0] OUTSEL_RST = 32'h09080705;

   localparam logic [CW-1:0] RUN_MIN = 7'h05;
   localparam logic [CW-1:0] RUN_MAX = 7'h64;
   localparam logic [CW-1:0] HOLD_MIN = 7'h05;
   localparam logic [CW-1:0] HOLD_MAX = 7'h32;
   localparam logic [PW-1:0] POS_RST = 24'h000000;
endpackage

// ---- hdl/mdc_route.sv ----
// Contact polarity and source selection for a group of command inputs
`timescale 1ns/1ps
module mdc_route #(
   parameter int W = 1
) (
   input wire logic [W-1:0] wired_i,
   input wire logic [W-1:0] link_i,
   input wire logic nc_i,
   input wire logic use_wired_i,
   output logic [W-1:0] y_o
);
   wire logic [W-1:0] active_w;

   // Break contact reads as active when the line is open
   assign active_w = wired_i ^ {W{nc_i}};
   assign y_o = use_wired_i ? active_w : link_i;
endmodule

// ---- hdl/mdc_top.sv ----
// Motor driver I/O configuration: register file, input routing and output selection
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Start comes from link when setting is 0, wired when 1; resets to 1.
// - Wired stop ignored when disabled; link stop always acts.
// - Stop code: 0 immediate, 1 decelerate, 2/3 same plus current off (3 only at standstill).
// - Stop input is make contact at 0, break at 1; resets to break.
// - Link excite 1 energises at polarity 0; polarity 1 inverts; resets 0.
// - With link excitation, power-up state follows the polarity setting.
// - Each general output shows the function its code selects.
// - Output codes reset to 5, 7, 8 and 9.
// - Shared input is origin-return at 0, position preset at 1; resets 0.
// - Excitation from link at 0, from wired input at 1; resets 1.
// - Origin-return and jog requests from link at 0, wired at 1.
// - Six data select bits from link at 0, wired at 1; resets 1.
// - Winding-release input make at 0, break at 1; resets 0.
// - Overtravel from limits when enabled; limits always act while homing.
// - Limit, origin and sensor_a inputs make at 0, break at 1.
// - Overtravel stops immediately at 0, decelerates at 1; resets 0.
// - Signed 24-bit preset position, resets to zero.
// - Position-window output while position lies between the two areas.
// - Signed 24-bit encoder counter preset, resets to zero.
// - Running current 5 to 100 percent, resets to 100.
// - Standstill current 5 to 50 percent, resets to 50.
module mdc_top (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [mdc_pkg::AW-1:0] addr_i,
   input wire logic [mdc_pkg::DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [mdc_pkg::DW-1:0] rdata_o,
   input wire mdc_pkg::mdc_wired_s wired_i,
   input wire mdc_pkg::mdc_stat_s stat_i,
   input wire logic signed [mdc_pkg::PW-1:0] motor_pos_i,
   output mdc_pkg::mdc_cmd_s cmd_o,
   output logic [3:0] gen_out_o,
   output logic [mdc_pkg::PW-1:0] preset_pos_o,
   output logic [mdc_pkg::PW-1:0] enc_preset_o,
   output logic [mdc_pkg::CW-1:0] run_cur_o,
   output logic [mdc_pkg::CW-1:0] hold_cur_o,
   output logic [mdc_pkg::CW-1:0] cur_o
);
   mdc_pkg::mdc_cfg_s cfg_r;
   mdc_pkg::mdc_link_s link_r;
   logic [31:0] outsel_r;
   logic signed [mdc_pkg::PW-1:0] area1_r;
   logic signed [mdc_pkg::PW-1:0] area2_r;
   mdc_pkg::mdc_cmd_s cmd_nxt;
   logic [3:0] gen_nxt;
   logic [mdc_pkg::DW-1:0] rdata_nxt;

   wire logic wr_cfg;
   wire logic wr_outsel;
   wire logic wr_preset;
   wire logic wr_area1;
   wire logic wr_area2;
   wire logic wr_enc;
   wire logic wr_cur;
   wire logic wr_link;
   wire logic [mdc_pkg::DW-1:0] rd_mux;

   // Register write decode
   assign wr_cfg = wr_i && (addr_i == mdc_pkg::CFG_OFF);
   assign wr_outsel = wr_i && (addr_i == mdc_pkg::OUTSEL_OFF);
   assign wr_preset = wr_i && (addr_i == mdc_pkg::PRESET_OFF);
   assign wr_area1 = wr_i && (addr_i == mdc_pkg::AREA1_OFF);
   assign wr_area2 = wr_i && (addr_i == mdc_pkg::AREA2_OFF);
   assign wr_enc = wr_i && (addr_i == mdc_pkg::ENC_OFF);
   assign wr_cur = wr_i && (addr_i == mdc_pkg::CUR_OFF);
   assign wr_link = wr_i && (addr_i == mdc_pkg::LINK_OFF);

   function automatic logic [mdc_pkg::CW-1:0] clamp(input logic [mdc_pkg::CW-1:0] v,
      input logic [mdc_pkg::CW-1:0] lo, input logic [mdc_pkg::CW-1:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // Configuration registers
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         cfg_r <= mdc_pkg::CFG_RST;
         outsel_r <= mdc_pkg::OUTSEL_RST;
         link_r <= mdc_pkg::LINK_RST;
      end else begin
         if (wr_cfg) begin
            cfg_r <= wdata_i[15:0];
         end
         if (wr_outsel) begin
            outsel_r <= wdata_i & 32'h1f1f1f1f;
         end
         if (wr_link) begin
            link_r <= wdata_i[15:0];
         end
      end
   end

   // Position and current settings
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         preset_pos_o <= mdc_pkg::POS_RST;
         area1_r <= mdc_pkg::POS_RST;
         area2_r <= mdc_pkg::POS_RST;
         enc_preset_o <= mdc_pkg::POS_RST;
         run_cur_o <= mdc_pkg::RUN_MAX;
         hold_cur_o <= mdc_pkg::HOLD_MAX;
      end else begin
         if (wr_preset) begin
            preset_pos_o <= wdata_i[23:0];
         end
         if (wr_area1) begin
            area1_r <= wdata_i[23:0];
         end
         if (wr_area2) begin
            area2_r <= wdata_i[23:0];
         end
         if (wr_enc) begin
            enc_preset_o <= wdata_i[23:0];
         end
         if (wr_cur) begin
            run_cur_o <= clamp(wdata_i[6:0], mdc_pkg::RUN_MIN, mdc_pkg::RUN_MAX);
            hold_cur_o <= clamp(wdata_i[14:8], mdc_pkg::HOLD_MIN, mdc_pkg::HOLD_MAX);
         end
      end
   end

   // Input routing: polarity first, then source
   wire logic start_w;
   wire logic stop_wired_w;
   wire logic excite_wired_w;
   wire logic [2:0] motion_w;
   wire logic [5:0] data_w;
   wire logic release_w;
   wire logic [1:0] limit_w;
   wire logic origin_w;
   wire logic sensor_a_w;

   mdc_route #(.W(1)) u_start (
      .wired_i(wired_i.start), .link_i(link_r.start), .nc_i(1'b0),
      .use_wired_i(cfg_r.start_src), .y_o(start_w));
   mdc_route #(.W(1)) u_stop (
      .wired_i(wired_i.stop), .link_i(1'b0), .nc_i(cfg_r.stop_nc),
      .use_wired_i(1'b1), .y_o(stop_wired_w));
   mdc_route #(.W(1)) u_excite (
      .wired_i(wired_i.excite), .link_i(1'b0), .nc_i(1'b0),
      .use_wired_i(1'b1), .y_o(excite_wired_w));
   mdc_route #(.W(3)) u_motion (
      .wired_i({wired_i.home, wired_i.jog_pos, wired_i.jog_neg}),
      .link_i({link_r.home, link_r.jog_pos, link_r.jog_neg}), .nc_i(1'b0),
      .use_wired_i(cfg_r.motion_src), .y_o(motion_w));
   mdc_route #(.W(6)) u_data (
      .wired_i(wired_i.data_sel), .link_i(link_r.data_sel), .nc_i(1'b0),
      .use_wired_i(cfg_r.data_src), .y_o(data_w));
   mdc_route #(.W(1)) u_release (
      .wired_i(wired_i.winding_release), .link_i(1'b0), .nc_i(cfg_r.release_nc),
      .use_wired_i(1'b1), .y_o(release_w));
   mdc_route #(.W(2)) u_limit (
      .wired_i({wired_i.limit_pos, wired_i.limit_neg}), .link_i(2'h0),
      .nc_i(cfg_r.limit_nc), .use_wired_i(1'b1), .y_o(limit_w));
   mdc_route #(.W(1)) u_origin (
      .wired_i(wired_i.origin_sensor), .link_i(1'b0), .nc_i(cfg_r.origin_nc),
      .use_wired_i(1'b1), .y_o(origin_w));
   mdc_route #(.W(1)) u_sensor_a (
      .wired_i(wired_i.sensor_a), .link_i(1'b0), .nc_i(cfg_r.sensor_a_nc),
      .use_wired_i(1'b1), .y_o(sensor_a_w));

   // Stop, overtravel and excitation decisions
   wire logic stop_w;
   wire logic ot_w;
   wire logic excite_w;
   wire logic signed [mdc_pkg::PW-1:0] lo_w;
   wire logic signed [mdc_pkg::PW-1:0] hi_w;
   wire logic area_w;

   assign stop_w = (cfg_r.stop_en && stop_wired_w) || link_r.stop;
   assign ot_w = (limit_w != 2'h0) && (cfg_r.ot_en || stat_i.homing);
   assign excite_w = !release_w && (cfg_r.excite_src ? excite_wired_w :
      (link_r.excite ^ cfg_r.excite_pol));
   assign lo_w = (area1_r < area2_r) ? area1_r : area2_r;
   assign hi_w = (area1_r < area2_r) ? area2_r : area1_r;
   assign area_w = (motor_pos_i >= lo_w) && (motor_pos_i <= hi_w);

   always_comb begin
      cmd_nxt.start = start_w;
      cmd_nxt.stop_imm = stop_w && !cfg_r.stop_action[0];
      cmd_nxt.stop_decel = stop_w && cfg_r.stop_action[0];
      cmd_nxt.current_off = stop_w && ((cfg_r.stop_action == mdc_pkg::STOP_IMM_OFF) ||
         ((cfg_r.stop_action == mdc_pkg::STOP_DECEL_OFF) && stat_i.standstill));
      cmd_nxt.excite = excite_w;
      cmd_nxt.home = motion_w[2] && !cfg_r.home_preset_sel;
      cmd_nxt.preset = motion_w[2] && cfg_r.home_preset_sel;
      cmd_nxt.jog_pos = motion_w[1];
      cmd_nxt.jog_neg = motion_w[0];
      cmd_nxt.data_sel = data_w;
      cmd_nxt.ot_imm = ot_w && !cfg_r.ot_decel;
      cmd_nxt.ot_decel = ot_w && cfg_r.ot_decel;
      cmd_nxt.origin = origin_w;
      cmd_nxt.sensor_a = sensor_a_w;
      cmd_nxt.limit_pos = limit_w[1];
      cmd_nxt.limit_neg = limit_w[0];
   end

   // General output function selection
   function automatic logic gsel(input logic [4:0] code, input logic area,
      input mdc_pkg::mdc_stat_s s, input logic [3:0] r);
      case (code)
         mdc_pkg::OSEL_AREA: gsel = area;
         mdc_pkg::OSEL_TIM: gsel = s.step_phase_timing;
         mdc_pkg::OSEL_READY: gsel = s.ready;
         mdc_pkg::OSEL_WARN: gsel = s.warning_flag;
         mdc_pkg::OSEL_ORIGIN: gsel = s.at_origin;
         mdc_pkg::OSEL_ZERO: gsel = s.encoder_zero_phase;
         mdc_pkg::OSEL_ROUT1: gsel = r[0];
         mdc_pkg::OSEL_ROUT2: gsel = r[1];
         mdc_pkg::OSEL_MISSTEP: gsel = s.misstep;
         mdc_pkg::OSEL_HEAT: gsel = s.overheat;
         mdc_pkg::OSEL_ROUT3: gsel = r[2];
         mdc_pkg::OSEL_ROUT4: gsel = r[3];
         default: gsel = 1'b0;
      endcase
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_out
         assign gen_nxt[gi] = gsel(outsel_r[8*gi +: 5], area_w, stat_i, link_r.rout);
      end
   endgenerate

   // Read multiplexer, zero for unmapped addresses
   assign rd_mux = (addr_i == mdc_pkg::CFG_OFF) ? {16'h0000, cfg_r} :
      (addr_i == mdc_pkg::OUTSEL_OFF) ? outsel_r :
      (addr_i == mdc_pkg::PRESET_OFF) ? {{8{preset_pos_o[23]}}, preset_pos_o} :
      (addr_i == mdc_pkg::AREA1_OFF) ? {{8{area1_r[23]}}, area1_r} :
      (addr_i == mdc_pkg::AREA2_OFF) ? {{8{area2_r[23]}}, area2_r} :
      (addr_i == mdc_pkg::ENC_OFF) ? {{8{enc_preset_o[23]}}, enc_preset_o} :
      (addr_i == mdc_pkg::CUR_OFF) ? {17'h00000, hold_cur_o, 1'b0, run_cur_o} :
      (addr_i == mdc_pkg::LINK_OFF) ? {16'h0000, link_r} :
      (addr_i == mdc_pkg::STAT_OFF) ? {6'h00, area_w, gen_out_o, cmd_o} :
      32'h00000000;
   assign rdata_nxt = rd_i ? rd_mux : 32'h00000000;

   // Registered outputs
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         cmd_o <= '0;
         gen_out_o <= 4'h0;
         rdata_o <= 32'h00000000;
         cur_o <= mdc_pkg::RUN_MAX;
      end else begin
         cmd_o <= cmd_nxt;
         gen_out_o <= gen_nxt;
         rdata_o <= rdata_nxt;
         cur_o <= stat_i.standstill ? hold_cur_o : run_cur_o;
      end
   end

   // Checks
   sequence s_decel_stop;
      stop_w ##0 (cfg_r.stop_action == mdc_pkg::STOP_DECEL);
   endsequence

   sequence s_homing_limit;
      stat_i.homing ##0 (limit_w != 2'h0);
   endsequence

   a_start_link: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      !cfg_r.start_src |=> cmd_o.start == $past(link_r.start))
      else $error("start not taken from link");

   a_start_wired: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      cfg_r.start_src |=> cmd_o.start == $past(wired_i.start))
      else $error("start not taken from wired input");

   a_stop_ignored: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (!cfg_r.stop_en && !link_r.stop) |=> !cmd_o.stop_imm && !cmd_o.stop_decel)
      else $error("disabled wired stop acted");

   a_stop_decel: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      s_decel_stop |=> cmd_o.stop_decel && !cmd_o.stop_imm && !cmd_o.current_off)
      else $error("decelerate stop code misapplied");

   a_stop_contact: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (cfg_r.stop_en && !link_r.stop && cfg_r.stop_action == mdc_pkg::STOP_IMM)
      |=> cmd_o.stop_imm == $past(wired_i.stop ^ cfg_r.stop_nc))
      else $error("stop contact polarity wrong");

   a_excite_map: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (!cfg_r.excite_src && !release_w)
      |=> cmd_o.excite == $past(link_r.excite ^ cfg_r.excite_pol))
      else $error("link excitation mapping wrong");

   a_outsel_reset: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $past(!nrst_i) |-> outsel_r == mdc_pkg::OUTSEL_RST ##1 cmd_o.excite == $past(excite_w))
      else $error("output codes not at default after reset");

   a_area_out: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (outsel_r[4:0] == mdc_pkg::OSEL_AREA) |=> gen_out_o[0] == $past(area_w))
      else $error("position window not on output 1");

   a_ot_homing: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      s_homing_limit |=> (cmd_o.ot_imm != cmd_o.ot_decel) && cmd_o.ot_decel == $past(cfg_r.ot_decel))
      else $error("limit ignored during origin return");

   a_cur_range: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      wr_cur |=> run_cur_o >= mdc_pkg::RUN_MIN && run_cur_o <= mdc_pkg::RUN_MAX &&
      hold_cur_o >= mdc_pkg::HOLD_MIN && hold_cur_o <= mdc_pkg::HOLD_MAX ##1
      cur_o == ($past(stat_i.standstill) ? $past(hold_cur_o) : $past(run_cur_o)))
      else $error("current setting out of range");
endmodule

// ---- verif/mdc_switch_model.sv ----
// Far-side switches and sensors: make or break contacts seen at the wired inputs
`timescale 1ns/1ps
module mdc_switch_model (
   input wire logic ref_clk_i,
   input wire mdc_pkg::mdc_wired_s want_i,
   input wire mdc_pkg::mdc_wired_s brk_i,
   output mdc_pkg::mdc_wired_s wired_o
);
   // A break contact opens when actuated, a make contact closes
   always_ff @(posedge ref_clk_i) begin
      wired_o <= mdc_pkg::mdc_wired_s'(want_i ^ brk_i);
   end
endmodule

// ---- verif/mdc_top_tb_top.sv ----
// Self-checking testbench for the motor driver I/O configuration block
`timescale 1ns/1ps
module mdc_top_tb_top;
   logic ref_clk_i, nrst_i, wr_i, rd_i;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o, v;
   mdc_pkg::mdc_wired_s want, brk, wired;
   mdc_pkg::mdc_stat_s stat_i;
   logic signed [23:0] motor_pos_i;
   mdc_pkg::mdc_cmd_s cmd_o;
   logic [3:0] gen_out_o;
   logic [23:0] preset_pos_o, enc_preset_o;
   logic [6:0] run_cur_o, hold_cur_o, cur_o;
   mdc_pkg::mdc_cfg_s c;
   mdc_pkg::mdc_link_s l;
   int miscompares, checked, cycles;

   mdc_switch_model sw (.ref_clk_i(ref_clk_i), .want_i(want), .brk_i(brk), .wired_o(wired));
   mdc_top uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wired_i(wired), .stat_i(stat_i),
      .motor_pos_i(motor_pos_i), .cmd_o(cmd_o), .gen_out_o(gen_out_o),
      .preset_pos_o(preset_pos_o), .enc_preset_o(enc_preset_o), .run_cur_o(run_cur_o),
      .hold_cur_o(hold_cur_o), .cur_o(cur_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask

   task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      chk(n, e, rdata_o);
   endtask

   task setcfg(input mdc_pkg::mdc_cfg_s x);
      wr(mdc_pkg::CFG_OFF, {16'h0, x});
   endtask

   task settle;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask

   task t_reset;
      rchk("cfg", mdc_pkg::CFG_OFF, 32'h00000b97);
      rchk("outsel", mdc_pkg::OUTSEL_OFF, 32'h09080705);
      rchk("current", mdc_pkg::CUR_OFF, 32'h00003264);
      rchk("preset", mdc_pkg::PRESET_OFF, 32'h0);
      rchk("area1", mdc_pkg::AREA1_OFF, 32'h0);
      rchk("area2", mdc_pkg::AREA2_OFF, 32'h0);
      rchk("enc", mdc_pkg::ENC_OFF, 32'h0);
      rchk("unmapped", 8'h24, 32'h0);
      rchk("status", mdc_pkg::STAT_OFF, 32'h02200000);
      chk("cmd", 32'h0, cmd_o);
      chk("cur", 32'd100, cur_o);
      $display("test reset done");
   endtask

   task t_stop;
      c = mdc_pkg::CFG_RST;
      @(posedge ref_clk_i);
      stat_i.standstill <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         c.stop_action = k[1:0];
         setcfg(c);
         want.stop <= 1'b1;
         settle;
         chk("stop_imm", !k[0], cmd_o.stop_imm);
         chk("stop_decel", k[0], cmd_o.stop_decel);
         chk("current_off", k[1], cmd_o.current_off);
         @(posedge ref_clk_i);
         want.stop <= 1'b0;
      end
      c.stop_en = 1'b0;
      c.stop_action = mdc_pkg::STOP_DECEL;
      setcfg(c);
      want.stop <= 1'b1;
      settle;
      chk("stop_ignored", 32'h0, cmd_o.stop_decel);
      l = '0;
      l.stop = 1'b1;
      wr(mdc_pkg::LINK_OFF, {16'h0, l});
      settle;
      chk("stop_link", 32'h1, cmd_o.stop_decel);
      wr(mdc_pkg::LINK_OFF, 32'h0);
      want.stop <= 1'b0;
      brk.stop <= 1'b0;
      c.stop_en = 1'b1;
      c.stop_nc = 1'b0;
      setcfg(c);
      settle;
      chk("stop_make_idle", 32'h0, cmd_o.stop_decel);
      @(posedge ref_clk_i);
      want.stop <= 1'b1;
      settle;
      chk("stop_make", 32'h1, cmd_o.stop_decel);
      @(posedge ref_clk_i);
      want.stop <= 1'b0;
      brk.stop <= 1'b1;
      stat_i.standstill <= 1'b0;
      setcfg(mdc_pkg::CFG_RST);
      $display("test stop done");
   endtask

   task t_src;
      c = mdc_pkg::CFG_RST;
      c.excite_src = 1'b0;
      c.excite_pol = 1'b1;
      setcfg(c);
      settle;
      chk("excite_powerup", 32'h1, cmd_o.excite);
      l = '0;
      l.excite = 1'b1;
      l.jog_neg = 1'b1;
      l.data_sel = 6'h15;
      wr(mdc_pkg::LINK_OFF, {16'h0, l});
      want.start <= 1'b1;
      want.home <= 1'b1;
      want.jog_pos <= 1'b1;
      want.data_sel <= 6'h2a;
      for (int s = 0; s < 2; s++) begin
         c.start_src = s[0];
         c.excite_src = s[0];
         c.motion_src = s[0];
         c.data_src = s[0];
         c.excite_pol = 1'b0;
         setcfg(c);
         settle;
         chk("routed", s[0] ? 32'h5aa : 32'h255, {cmd_o.start, cmd_o.excite, cmd_o.home,
            cmd_o.jog_pos, cmd_o.jog_neg, cmd_o.data_sel});
      end
      c.home_preset_sel = 1'b1;
      setcfg(c);
      want.excite <= 1'b1;
      want.winding_release <= 1'b1;
      settle;
      chk("preset_req", 32'h1, {cmd_o.home, cmd_o.preset});
      chk("release_make", 32'h0, cmd_o.excite);
      c.release_nc = 1'b1;
      setcfg(c);
      want.winding_release <= 1'b0;
      brk.winding_release <= 1'b1;
      settle;
      chk("release_break", 32'h1, cmd_o.excite);
      wr(mdc_pkg::LINK_OFF, 32'h0);
      want <= '0;
      brk.winding_release <= 1'b0;
      setcfg(mdc_pkg::CFG_RST);
      $display("test source done");
   endtask

   task drive_fn(input logic [4:0] k, input logic b);
      mdc_pkg::mdc_stat_s s;
      s = {9{~b}};
      l = '0;
      l.rout = {4{~b}};
      case (k)
         5'h06: s.step_phase_timing = b;
         5'h07: s.ready = b;
         5'h08: s.warning_flag = b;
         5'h09: s.at_origin = b;
         5'h0a: s.encoder_zero_phase = b;
         5'h0b: l.rout[0] = b;
         5'h0c: l.rout[1] = b;
         5'h0d: s.misstep = b;
         5'h0e: s.overheat = b;
         5'h0f: l.rout[2] = b;
         5'h10: l.rout[3] = b;
         default: ;
      endcase
      wr(mdc_pkg::LINK_OFF, {16'h0, l});
      stat_i <= s;
      motor_pos_i <= ((k == 5'h05) == b) ? 24'sh0 : 24'sh5;
   endtask

   task t_out;
      int p[4] = '{-11, -10, 20, 21};
      for (int k = 5; k < 17; k++) begin
         wr(mdc_pkg::OUTSEL_OFF, {24'h090807, 3'h0, k[4:0]});
         for (int b = 0; b < 2; b++) begin
            drive_fn(k[4:0], b[0]);
            settle;
            chk("gen_out_1", b[0], gen_out_o[0]);
         end
      end
      wr(mdc_pkg::OUTSEL_OFF, 32'h09080705);
      wr(mdc_pkg::LINK_OFF, 32'h0);
      stat_i <= '0;
      wr(mdc_pkg::AREA1_OFF, 32'hfffffff6);
      wr(mdc_pkg::AREA2_OFF, 32'd20);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk_i);
         motor_pos_i <= p[i][23:0];
         settle;
         chk("area", i == 1 || i == 2, gen_out_o[0]);
      end
      $display("test outputs done");
   endtask

   task t_ot;
      c = mdc_pkg::CFG_RST;
      @(posedge ref_clk_i);
      want.limit_pos <= 1'b1;
      settle;
      chk("ot_imm", 32'h2, {cmd_o.ot_imm, cmd_o.ot_decel});
      c.ot_decel = 1'b1;
      setcfg(c);
      settle;
      chk("ot_decel", 32'h1, {cmd_o.ot_imm, cmd_o.ot_decel});
      c.ot_en = 1'b0;
      setcfg(c);
      settle;
      chk("ot_off", 32'h0, {cmd_o.ot_imm, cmd_o.ot_decel});
      @(posedge ref_clk_i);
      stat_i.homing <= 1'b1;
      settle;
      chk("ot_homing", 32'h1, {cmd_o.ot_imm, cmd_o.ot_decel});
      c = mdc_pkg::CFG_RST;
      c.limit_nc = 1'b1;
      c.origin_nc = 1'b1;
      c.sensor_a_nc = 1'b1;
      setcfg(c);
      stat_i.homing <= 1'b0;
      want.limit_pos <= 1'b0;
      want.origin_sensor <= 1'b1;
      brk.limit_pos <= 1'b1;
      brk.limit_neg <= 1'b1;
      brk.origin_sensor <= 1'b1;
      brk.sensor_a <= 1'b1;
      settle;
      chk("nc_inputs", 32'h8, {cmd_o.ot_imm, cmd_o.origin, cmd_o.sensor_a,
         cmd_o.limit_neg, cmd_o.limit_pos});
      @(posedge ref_clk_i);
      want <= '0;
      brk <= '0;
      brk.stop <= 1'b1;
      setcfg(mdc_pkg::CFG_RST);
      $display("test overtravel done");
   endtask

   task t_cur;
      wr(mdc_pkg::CUR_OFF, 32'h00003c02);
      rchk("cur_clamp", mdc_pkg::CUR_OFF, 32'h00003205);
      @(posedge ref_clk_i);
      stat_i.standstill <= 1'b1;
      settle;
      chk("cur_hold", 32'd50, cur_o);
      wr(mdc_pkg::CUR_OFF, 32'h00001464);
      stat_i.standstill <= 1'b0;
      settle;
      chk("cur_run", 32'd100, cur_o);
      chk("hold_cur", 32'd20, hold_cur_o);
      wr(mdc_pkg::PRESET_OFF, 32'h00800000);
      rchk("preset", mdc_pkg::PRESET_OFF, 32'hff800000);
      chk("preset_pos", 32'h800000, preset_pos_o);
      wr(mdc_pkg::ENC_OFF, 32'h007fffff);
      rchk("enc", mdc_pkg::ENC_OFF, 32'h007fffff);
      chk("enc_pos", 32'h7fffff, enc_preset_o);
      $display("test current done");
   endtask

   task wrap_up;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up;
      end
   end

   initial begin
      nrst_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      stat_i = '0;
      motor_pos_i = 24'sh0;
      want = '0;
      brk = '0;
      brk.stop = 1'b1;
      repeat (2) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      t_reset;
      t_stop;
      t_src;
      t_out;
      t_ot;
      t_cur;
      wrap_up;
   end
endmodule
